// [pin_source.sv]
// Behavioural source of the count and trigger pins seen by the timer unit.
module pin_source (
  // Clock
  input  wire logic       clk,
  // Request from the bench
  input  wire logic [1:0] sel,
  input  wire logic [7:0] n_edges,
  input  wire logic       go,
  // Pins and status
  output logic [3:0]      pins,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_reg;
  logic [3:0] ph_reg;

  initial begin
    pins = 4'hf;
    busy = 1'b0;
    left_reg = 8'h00;
    ph_reg = 4'h0;
  end

  // ---------------------------------------------------------------
  // Pulse train
  // ---------------------------------------------------------------
  // Each level lasts eight clocks, two full machine cycles, so every level is sampled.
  always @(posedge clk) begin
    if (go && !busy) begin
      left_reg <= n_edges;
      busy <= 1'b1;
      ph_reg <= 4'h0;
    end else if (busy) begin
      ph_reg <= ph_reg + 4'h1;
      if (ph_reg == 4'h7) pins[sel] <= 1'b0;
      if (ph_reg == 4'hf) begin
        pins[sel] <= 1'b1;
        left_reg <= left_reg - 8'h01;
        if (left_reg == 8'h01) busy <= 1'b0;
      end
    end
  end
endmodule : pin_source

// [tcu_pkg.sv]
// Constants shared by the three timer/counter unit.
package tcu_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_CLK    = 8'h08;
  localparam logic [7:0] ADDR_LO0    = 8'h0c;
  localparam logic [7:0] ADDR_HI0    = 8'h10;
  localparam logic [7:0] ADDR_LO1    = 8'h14;
  localparam logic [7:0] ADDR_HI1    = 8'h18;
  localparam logic [7:0] ADDR_CTL2   = 8'h1c;
  localparam logic [7:0] ADDR_MD2    = 8'h20;
  localparam logic [7:0] ADDR_LO2    = 8'h24;
  localparam logic [7:0] ADDR_HI2    = 8'h28;
  localparam logic [7:0] ADDR_CAPLO  = 8'h2c;
  localparam logic [7:0] ADDR_CAPHI  = 8'h30;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MD_GATE1 = 7;
  localparam int MD_FSEL1 = 6;
  localparam int MD_GATE0 = 3;
  localparam int MD_FSEL0 = 2;
  localparam int CTL_OVF1 = 7;
  localparam int CTL_RUN1 = 6;
  localparam int CTL_OVF0 = 5;
  localparam int CTL_RUN0 = 4;
  localparam int CK_TURBO0 = 3;
  localparam int CK_TURBO1 = 4;
  localparam int CK_TURBO2 = 5;
  localparam int C2_OVF  = 7;
  localparam int C2_EXT  = 6;
  localparam int C2_RXB  = 5;
  localparam int C2_TXB  = 4;
  localparam int C2_EXEN = 3;
  localparam int C2_RUN  = 2;
  localparam int C2_SRC  = 1;
  localparam int C2_CAP  = 0;
  localparam int TM_CLR  = 3;
  localparam int TM_OE   = 1;
  localparam int TM_DIR  = 0;
  localparam int PIN_C0   = 0;
  localparam int PIN_C1   = 1;
  localparam int PIN_C2   = 2;
  localparam int PIN_TRIG = 3;
  // ---------------------------------------------------------------
  // Modes, phases, limits and bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_13BIT  = 2'b00;
  localparam logic [1:0] MODE_16BIT  = 2'b01;
  localparam logic [1:0] MODE_RELOAD = 2'b10;
  localparam logic [1:0] MODE_SPLIT  = 2'b11;
  localparam logic [1:0] PH_C3 = 2'd2;
  localparam logic [1:0] PH_C4 = 2'd3;
  localparam int unsigned STD_MC_PER_TICK = 3;
  localparam logic [12:0] MAX13 = 13'h1fff;
  localparam logic [15:0] MAX16 = 16'hffff;
  localparam logic [7:0]  MAX8  = 8'hff;
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
endpackage : tcu_pkg

// [three_timer_counter_unit.sv]
// Two four-mode timer/counters and a third capture/reload timer behind AXI4-Lite.
// Functional notes
// - Count pins are sampled once per machine cycle, in phase C4.
// - A count edge is a high sample followed by a low sample.
// - Counters update in phase C3, the clock-out counter every other clock; a detected edge counts next machine cycle.
// - Function bit 2 (timer 0) and bit 6 (timer 1) pick timer or counter.
// - Turbo bits pick clock/12 or clock/4; reset clears them.
// - Mode 0 is a 13-bit counter; wrap from 1fff sets the overflow flag.
// - Counting needs run set and either gate clear or interrupt pin high.
// - Mode 1 is a 16-bit counter; wrap from ffff sets the overflow flag.
// - Mode 2 counts the low byte and reloads it from the high byte.
// - Timer 1 in mode 3 holds its count.
// - Timer 0 mode 3 splits into two 8-bit timers; high uses timer 1 run/flag.
// - Then timer 1 still counts, gated by pin, without setting a flag.
// - Third timer counts pin edges or the divided clock, gated by its run bit.
// - Capture mode counts up; enabled trigger fall captures and sets external flag.
// - With capture-clear set, the count resets after each capture.
// - Up-only reload mode reloads on wrap or enabled trigger fall, setting flags.
// - Up/down mode reloads on overflow; down from capture value loads ffff.
// - In up/down mode each reload toggles the external flag, which never interrupts.
// - Baud selects reload on wrap silently; trigger fall still sets the external flag.
// - Clock-out mode drives a 50 percent square wave with no overflow interrupt.
// - Clock-out frequency is clock over four times (65536 minus capture).
module three_timer_counter_unit
  import tcu_pkg::*;
#(
  parameter int unsigned STD_PRESCALE = STD_MC_PER_TICK
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Count, gate and trigger pins
  input  wire logic        count_input_zero,
  input  wire logic        count_input_one,
  input  wire logic        count_input_two,
  input  wire logic        external_interrupt_pin_zero,
  input  wire logic        external_interrupt_pin_one,
  input  wire logic        trigger_direction_pin,
  // Flags, request and clock-out pin
  output logic             overflow_flag_zero,
  output logic             overflow_flag_one,
  output logic             third_overflow_flag,
  output logic             external_trigger_flag,
  output logic             third_irq,
  output logic             clock_out_o,
  output logic             clock_out_oe
);

  if (STD_PRESCALE < 1 || STD_PRESCALE > 4) begin : g_chk
    $error("STD_PRESCALE must lie between 1 and 4");
  end
  typedef struct packed {
    logic [1:0]  phase;
    logic [1:0]  mcdiv;
    logic [3:0]  smp;
    logic [3:0]  fall;
    logic [7:0]  mode_r;
    logic [7:0]  ctrl_r;
    logic [7:0]  clk_r;
    logic [7:0]  lo0;
    logic [7:0]  hi0;
    logic [7:0]  lo1;
    logic [7:0]  hi1;
    logic [7:0]  ctl2;
    logic [7:0]  md2;
    logic [7:0]  lo2;
    logic [7:0]  hi2;
    logic [7:0]  cap_lo;
    logic [7:0]  cap_hi;
    logic        clk_out;
    logic        irq2;
    logic        aw_rdy;
    logic        w_rdy;
    logic        ar_rdy;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [7:0]  w_data;
    logic        w_lane;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;
  state_t      st_reg, st_next;
  logic [3:0]  pins;
  logic        upd, base, tick0, tick1, run0, run1;
  logic        inc0, inc1, inc2, split, set0, set1, set2, setx;
  logic        clko, quiet, updown, wrap2, trig, wr_go;
  logic [16:0] r0, r1;
  logic [15:0] c2, cap;
  assign pins = {trigger_direction_pin, count_input_two, count_input_one, count_input_zero};
  // Returns {overflow, high byte, low byte} after one count in the given mode.
  function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [12:0] v13;
    v13 = 13'({hi, lo[4:0]} + 13'h1);
    case (m)
      MODE_13BIT:  step = {({hi, lo[4:0]} == MAX13), v13[12:5], lo[7:5], v13[4:0]};
      MODE_16BIT:  step = {({hi, lo} == MAX16), 16'({hi, lo} + 16'h1)};
      MODE_RELOAD: step = (lo == MAX8) ? {1'b1, hi, hi} : {1'b0, hi, 8'(lo + 8'h1)};
      default:     step = {(lo == MAX8), hi, 8'(lo + 8'h1)};
    endcase
  endfunction : step
  always_comb begin
    st_next = st_reg;
    set0    = 1'b0;
    set1    = 1'b0;
    set2    = 1'b0;
    setx    = 1'b0;
    wr_go   = 1'b0;
    c2      = {st_reg.hi2, st_reg.lo2};
    cap     = {st_reg.cap_hi, st_reg.cap_lo};
    // ---------------------------------------------------------------
    // Machine-cycle phases and pin sampling
    // ---------------------------------------------------------------
    st_next.phase = 2'(st_reg.phase + 2'd1);
    if (st_reg.phase == PH_C4) begin
      st_next.smp   = pins;
      st_next.fall  = st_reg.smp & ~pins;
      st_next.mcdiv = (st_reg.mcdiv == 2'(STD_PRESCALE - 1)) ? 2'd0 : 2'(st_reg.mcdiv + 2'd1);
    end
    upd   = (st_reg.phase == PH_C3);
    base  = (st_reg.mcdiv == 2'd0);
    tick0 = upd && (st_reg.clk_r[CK_TURBO0] || base);
    tick1 = upd && (st_reg.clk_r[CK_TURBO1] || base);
    // ---------------------------------------------------------------
    // Timer/counters 0 and 1
    // ---------------------------------------------------------------
    split = (st_reg.mode_r[1:0] == MODE_SPLIT);
    run0  = st_reg.ctrl_r[CTL_RUN0]
            && (!st_reg.mode_r[MD_GATE0] || external_interrupt_pin_zero);
    inc0  = run0 && (st_reg.mode_r[MD_FSEL0] ? (upd && st_reg.fall[PIN_C0]) : tick0);
    r0    = step(st_reg.mode_r[1:0], st_reg.lo0, st_reg.hi0);
    if (inc0) begin
      st_next.lo0 = r0[7:0];
      if (!split) begin
        st_next.hi0 = r0[15:8];
      end
      set0 = r0[16];
    end
    if (split && tick0 && st_reg.ctrl_r[CTL_RUN1]) begin
      st_next.hi0 = 8'(st_reg.hi0 + 8'h1);
      set1 = (st_reg.hi0 == MAX8);
    end
    run1 = (!st_reg.mode_r[MD_GATE1] || external_interrupt_pin_one)
           && (split || st_reg.ctrl_r[CTL_RUN1]);
    inc1 = run1 && (st_reg.mode_r[5:4] != MODE_SPLIT)
           && (st_reg.mode_r[MD_FSEL1] ? (upd && st_reg.fall[PIN_C1]) : tick1);
    r1 = step(st_reg.mode_r[5:4], st_reg.lo1, st_reg.hi1);
    if (inc1) begin
      st_next.lo1 = r1[7:0];
      st_next.hi1 = r1[15:8];
      if (!split) begin
        set1 = r1[16];
      end
    end
    // ---------------------------------------------------------------
    // Third timer
    // ---------------------------------------------------------------
    clko   = st_reg.md2[TM_OE] && !st_reg.ctl2[C2_SRC] && !st_reg.ctl2[C2_CAP];
    quiet  = st_reg.ctl2[C2_RXB] || st_reg.ctl2[C2_TXB] || clko;
    updown = !quiet && !st_reg.ctl2[C2_CAP] && st_reg.md2[TM_DIR];
    wrap2  = (c2 == MAX16);
    trig   = upd && st_reg.fall[PIN_TRIG] && st_reg.ctl2[C2_EXEN];
    inc2   = st_reg.ctl2[C2_RUN] && (st_reg.ctl2[C2_SRC] ? (upd && st_reg.fall[PIN_C2])
             : clko ? st_reg.phase[0]
             : (upd && (st_reg.clk_r[CK_TURBO2] || base)));
    if (quiet) begin
      if (inc2) begin
        c2 = wrap2 ? cap : 16'(c2 + 16'h1);
        if (wrap2 && clko) begin
          st_next.clk_out = !st_reg.clk_out;
        end
      end
      setx = trig;
    end else if (st_reg.ctl2[C2_CAP]) begin
      if (inc2) begin
        c2   = 16'(c2 + 16'h1);
        set2 = wrap2;
      end
      if (trig) begin
        st_next.cap_hi = st_reg.hi2;
        st_next.cap_lo = st_reg.lo2;
        setx = 1'b1;
        if (st_reg.md2[TM_CLR]) begin
          c2 = '0;
        end
      end
    end else if (updown) begin
      if (inc2) begin
        if (st_reg.smp[PIN_TRIG]) begin
          c2   = wrap2 ? cap : 16'(c2 + 16'h1);
          set2 = wrap2;
        end else begin
          c2   = (c2 == cap) ? MAX16 : 16'(c2 - 16'h1);
          set2 = ({st_reg.hi2, st_reg.lo2} == cap);
        end
        if (set2) begin
          st_next.ctl2[C2_EXT] = !st_reg.ctl2[C2_EXT];
        end
      end
    end else begin
      if (inc2) begin
        c2   = wrap2 ? cap : 16'(c2 + 16'h1);
        set2 = wrap2;
      end
      if (trig) begin
        c2   = cap;
        setx = 1'b1;
      end
    end
    st_next.hi2 = c2[15:8];
    st_next.lo2 = c2[7:0];
    // ---------------------------------------------------------------
    // AXI4-Lite slave
    // ---------------------------------------------------------------
    if (awvalid && st_reg.aw_rdy) begin
      st_next.aw_rdy  = 1'b0;
      st_next.aw_held = 1'b1;
      st_next.aw_addr = {awaddr[7:2], 2'b00};
    end
    if (wvalid && st_reg.w_rdy) begin
      st_next.w_rdy  = 1'b0;
      st_next.w_held = 1'b1;
      st_next.w_data = wdata[7:0];
      st_next.w_lane = wstrb[0];
    end
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
      st_next.aw_rdy = 1'b1;
      st_next.w_rdy  = 1'b1;
    end
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
      wr_go           = st_reg.w_lane;
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = RESP_OK;
      case (st_reg.aw_addr)
        ADDR_MODE:  if (wr_go) st_next.mode_r = st_reg.w_data;
        ADDR_CTRL:  if (wr_go) st_next.ctrl_r = st_reg.w_data;
        ADDR_CLK:   if (wr_go) st_next.clk_r  = st_reg.w_data;
        ADDR_LO0:   if (wr_go) st_next.lo0    = st_reg.w_data;
        ADDR_HI0:   if (wr_go) st_next.hi0    = st_reg.w_data;
        ADDR_LO1:   if (wr_go) st_next.lo1    = st_reg.w_data;
        ADDR_HI1:   if (wr_go) st_next.hi1    = st_reg.w_data;
        ADDR_CTL2:  if (wr_go) st_next.ctl2   = st_reg.w_data;
        ADDR_MD2:   if (wr_go) st_next.md2    = st_reg.w_data;
        ADDR_LO2:   if (wr_go) st_next.lo2    = st_reg.w_data;
        ADDR_HI2:   if (wr_go) st_next.hi2    = st_reg.w_data;
        ADDR_CAPLO: if (wr_go) st_next.cap_lo = st_reg.w_data;
        ADDR_CAPHI: if (wr_go) st_next.cap_hi = st_reg.w_data;
        default: begin
          wr_go         = 1'b0;
          st_next.bresp = RESP_ERR;
        end
      endcase
    end
    // Hardware setting a flag wins over a software clear in the same cycle, except the up/down-mode toggle of the external flag.
    if (set0) st_next.ctrl_r[CTL_OVF0] = 1'b1;
    if (set1) st_next.ctrl_r[CTL_OVF1] = 1'b1;
    if (set2 && !quiet) st_next.ctl2[C2_OVF] = 1'b1;
    if (setx) st_next.ctl2[C2_EXT] = 1'b1;
    st_next.irq2 = st_next.ctl2[C2_OVF] || (st_next.ctl2[C2_EXT]
                   && !(st_next.md2[TM_DIR] && !st_next.ctl2[C2_CAP]
                   && !st_next.ctl2[C2_RXB] && !st_next.ctl2[C2_TXB]));
    if (arvalid && st_reg.ar_rdy) begin
      st_next.ar_rdy = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OK;
      st_next.rdata  = '0;
      case ({araddr[7:2], 2'b00})
        ADDR_MODE:  st_next.rdata[7:0] = st_reg.mode_r;
        ADDR_CTRL:  st_next.rdata[7:0] = st_reg.ctrl_r;
        ADDR_CLK:   st_next.rdata[7:0] = st_reg.clk_r;
        ADDR_LO0:   st_next.rdata[7:0] = st_reg.lo0;
        ADDR_HI0:   st_next.rdata[7:0] = st_reg.hi0;
        ADDR_LO1:   st_next.rdata[7:0] = st_reg.lo1;
        ADDR_HI1:   st_next.rdata[7:0] = st_reg.hi1;
        ADDR_CTL2:  st_next.rdata[7:0] = st_reg.ctl2;
        ADDR_MD2:   st_next.rdata[7:0] = st_reg.md2;
        ADDR_LO2:   st_next.rdata[7:0] = st_reg.lo2;
        ADDR_HI2:   st_next.rdata[7:0] = st_reg.hi2;
        ADDR_CAPLO: st_next.rdata[7:0] = st_reg.cap_lo;
        ADDR_CAPHI: st_next.rdata[7:0] = st_reg.cap_hi;
        default:    st_next.rresp = RESP_ERR;
      endcase
    end
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
      st_next.ar_rdy = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg        <= '0;
      st_reg.aw_rdy <= 1'b1;
      st_reg.w_rdy  <= 1'b1;
      st_reg.ar_rdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign awready               = st_reg.aw_rdy;
  assign wready                = st_reg.w_rdy;
  assign bvalid                = st_reg.bvalid;
  assign bresp                 = st_reg.bresp;
  assign arready               = st_reg.ar_rdy;
  assign rvalid                = st_reg.rvalid;
  assign rdata                 = st_reg.rdata;
  assign rresp                 = st_reg.rresp;
  assign overflow_flag_zero    = st_reg.ctrl_r[CTL_OVF0];
  assign overflow_flag_one     = st_reg.ctrl_r[CTL_OVF1];
  assign third_overflow_flag   = st_reg.ctl2[C2_OVF];
  assign external_trigger_flag = st_reg.ctl2[C2_EXT];
  assign third_irq             = st_reg.irq2;
  assign clock_out_o           = st_reg.clk_out;
  assign clock_out_oe          = st_reg.md2[TM_OE];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence fall0_s;
    st_reg.phase == PH_C4 && st_reg.smp[PIN_C0] && !pins[PIN_C0];
  endsequence
  sequence capture_s;
    trig && !quiet && st_reg.ctl2[C2_CAP] && !wr_go;
  endsequence
  sample_c4_a: assert property ($changed(st_reg.smp) |-> $past(st_reg.phase) == PH_C4)
    else $error("Pin sample changed outside phase C4");
  fall_detect_a: assert property (fall0_s |=> st_reg.fall[PIN_C0] ##2 upd)
    else $error("Falling edge not recorded before next update");
  c3_update_a: assert property ($changed(st_reg.lo1)
    |-> ($past(st_reg.phase) == PH_C3 || $past(wr_go)))
    else $error("Timer 1 count changed outside phase C3");
  mode0_wrap_a: assert property ((inc1 && !wr_go && !split && st_reg.mode_r[5:4] == MODE_13BIT
    && {st_reg.hi1, st_reg.lo1[4:0]} == MAX13)
    |=> (st_reg.ctrl_r[CTL_OVF1] && st_reg.hi1 == 8'h00 && st_reg.lo1[4:0] == 5'h00))
    else $error("Mode 0 wrap wrong");
  gate_hold_a: assert property ((!run0 && !wr_go) |=> $stable(st_reg.lo0))
    else $error("Timer 0 counted while disabled");
  reload8_a: assert property ((inc0 && !wr_go && st_reg.mode_r[1:0] == MODE_RELOAD
    && st_reg.lo0 == MAX8) |=> (st_reg.lo0 == $past(st_reg.hi0) && $stable(st_reg.hi0)))
    else $error("Mode 2 reload wrong");
  freeze_a: assert property ((st_reg.mode_r[5:4] == MODE_SPLIT && !wr_go)
    |=> $stable({st_reg.hi1, st_reg.lo1}))
    else $error("Timer 1 moved in mode 3");
  capture_a: assert property (capture_s |=> ({st_reg.cap_hi, st_reg.cap_lo}
    == $past({st_reg.hi2, st_reg.lo2}) && st_reg.ctl2[C2_EXT]))
    else $error("Capture did not store count");
  clear_a: assert property ((capture_s and st_reg.md2[TM_CLR])
    |=> {st_reg.hi2, st_reg.lo2} == 16'h0000)
    else $error("Count not cleared after capture");
  down_reload_a: assert property ((inc2 && updown && !st_reg.smp[PIN_TRIG] && !wr_go
    && {st_reg.hi2, st_reg.lo2} == cap)
    |=> ({st_reg.hi2, st_reg.lo2} == MAX16 && st_reg.ctl2[C2_OVF]))
    else $error("Down reload wrong");
  updown_irq_a: assert property ((updown && !st_reg.ctl2[C2_OVF]) |-> !st_reg.irq2)
    else $error("External flag raised request in up/down mode");
  quiet_wrap_a: assert property ((inc2 && quiet && wrap2 && !st_reg.ctl2[C2_OVF] && !wr_go)
    |=> (!st_reg.ctl2[C2_OVF] && {st_reg.hi2, st_reg.lo2} == $past(cap)))
    else $error("Baud wrap set overflow flag or missed reload");
  clkout_a: assert property ((inc2 && clko && wrap2)
    |=> st_reg.clk_out != $past(st_reg.clk_out))
    else $error("Clock-out did not toggle on wrap");

endmodule : three_timer_counter_unit

// [three_timer_counter_unit_bench.sv]
// Self-checking bench for the three timer/counter unit.
module three_timer_counter_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tcu_pkg::*;
  logic clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic go = 0, dir_hold = 1, external_interrupt_pin_zero = 1, external_interrupt_pin_one = 1;
  logic [7:0] awaddr = 0, araddr = 0, n_edges = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic [1:0] sel = 0;
  logic [3:0] pins;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp, last_resp;
  logic awready, wready, bvalid, arready, rvalid, busy, third_irq, clock_out_o, clock_out_oe;
  logic overflow_flag_zero, overflow_flag_one, third_overflow_flag, external_trigger_flag;
  int n_fail = 0, n_tests = 0;

  three_timer_counter_unit i_three_timer_counter_unit (.*, .count_input_zero(pins[PIN_C0]),
    .count_input_one(pins[PIN_C1]), .count_input_two(pins[PIN_C2]),
    .trigger_direction_pin(pins[PIN_TRIG] && dir_hold));
  pin_source i_pin_source (.clk(clk), .sel(sel), .n_edges(n_edges), .go(go), .pins(pins),
    .busy(busy));

  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    last_resp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    last_resp = rresp;
    chk(nm, {24'h0, e}, rdata);
    @(posedge clk);
  endtask : rd
  task automatic pulse(input logic [1:0] s, input logic [7:0] n);
    sel <= s;
    n_edges <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (busy);
    repeat (8) @(posedge clk);
  endtask : pulse
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(ADDR_CLK, 8'h00, "clock ctrl");
    rd(8'h3c, 8'h00, "unmapped");
    chk("unmapped resp", RESP_ERR, last_resp);
    wr(8'h3c, 8'h00);
    chk("unmapped bresp", RESP_ERR, last_resp);
    $display("reset test done");
  endtask : t_reset
  task automatic t_t0;
    wr(ADDR_MODE, 8'h05);
    wr(ADDR_LO0, 8'hfe);
    wr(ADDR_HI0, 8'hff);
    wr(ADDR_CTRL, 8'h10);
    pulse(2'd0, 8'd3);
    rd(ADDR_LO0, 8'h01, "lo0 mode1");
    rd(ADDR_HI0, 8'h00, "hi0 mode1");
    chk("ovf0", 1, overflow_flag_zero);
    wr(ADDR_MODE, 8'h0d);
    wr(ADDR_CTRL, 8'h10);
    wr(ADDR_LO0, 8'h00);
    external_interrupt_pin_zero <= 1'b0;
    pulse(2'd0, 8'd2);
    rd(ADDR_LO0, 8'h00, "lo0 gated");
    external_interrupt_pin_zero <= 1'b1;
    pulse(2'd0, 8'd2);
    rd(ADDR_LO0, 8'h02, "lo0 open");
    wr(ADDR_MODE, 8'h06);
    wr(ADDR_HI0, 8'h40);
    wr(ADDR_LO0, 8'hfe);
    pulse(2'd0, 8'd3);
    rd(ADDR_LO0, 8'h41, "lo0 mode2");
    rd(ADDR_HI0, 8'h40, "hi0 mode2");
    chk("ovf0 mode2", 1, overflow_flag_zero);
    $display("timer zero test done");
  endtask : t_t0
  task automatic t_t1;
    wr(ADDR_MODE, 8'h40);
    wr(ADDR_LO1, 8'h1e);
    wr(ADDR_HI1, 8'hff);
    wr(ADDR_CTRL, 8'h40);
    pulse(2'd1, 8'd3);
    rd(ADDR_LO1, 8'h01, "lo1 mode0");
    rd(ADDR_HI1, 8'h00, "hi1 mode0");
    chk("ovf1", 1, overflow_flag_one);
    wr(ADDR_MODE, 8'h70);
    wr(ADDR_LO1, 8'h05);
    pulse(2'd1, 8'd2);
    rd(ADDR_LO1, 8'h05, "lo1 frozen");
    $display("timer one test done");
  endtask : t_t1
  task automatic t_t2;
    logic prev;
    int n;
    wr(ADDR_CTL2, 8'h0f);
    wr(ADDR_MD2, 8'h08);
    wr(ADDR_LO2, 8'h10);
    wr(ADDR_HI2, 8'h00);
    pulse(2'd2, 8'd2);
    pulse(2'd3, 8'd1);
    rd(ADDR_CAPLO, 8'h12, "capture lo");
    rd(ADDR_LO2, 8'h00, "lo2 cleared");
    chk("ext flag", 1, external_trigger_flag);
    chk("third irq", 1, third_irq);
    wr(ADDR_CTL2, 8'h00);
    wr(ADDR_MD2, 8'h02);
    wr(ADDR_CAPLO, 8'hf0);
    wr(ADDR_CAPHI, 8'hff);
    wr(ADDR_LO2, 8'hf0);
    wr(ADDR_HI2, 8'hff);
    wr(ADDR_CTL2, 8'h04);
    for (int k = 0; k < 2; k++) begin
      prev = clock_out_o;
      n = 0;
      while (clock_out_o === prev && n < 200) begin
        @(posedge clk);
        n++;
      end
    end
    chk("half period", 32, n);
    chk("clock out oe", 1, clock_out_oe);
    chk("no ovf irq", 0, third_irq);
    $display("third timer test done");
  endtask : t_t2
  task automatic t_updown;
    wr(ADDR_CTL2, 8'h00);
    wr(ADDR_MD2, 8'h01);
    wr(ADDR_CAPLO, 8'h00);
    wr(ADDR_CAPHI, 8'h01);
    wr(ADDR_LO2, 8'h02);
    wr(ADDR_HI2, 8'h01);
    wr(ADDR_CTL2, 8'h06);
    dir_hold <= 1'b0;
    pulse(2'd2, 8'd3);
    rd(ADDR_LO2, 8'hff, "lo2 down reload");
    rd(ADDR_HI2, 8'hff, "hi2 down reload");
    chk("down ovf", 1, third_overflow_flag);
    chk("down toggle", 1, external_trigger_flag);
    dir_hold <= 1'b1;
    pulse(2'd2, 8'd1);
    rd(ADDR_LO2, 8'h00, "lo2 up reload");
    chk("up toggle", 0, external_trigger_flag);
    wr(ADDR_CTL2, 8'h46);
    chk("no ext irq", 0, third_irq);
    wr(ADDR_MD2, 8'h00);
    wr(ADDR_CTL2, 8'h0e);
    pulse(2'd2, 8'd1);
    pulse(2'd3, 8'd1);
    rd(ADDR_LO2, 8'h00, "lo2 trigger reload");
    rd(ADDR_HI2, 8'h01, "hi2 trigger reload");
    chk("trigger ext flag", 1, external_trigger_flag);
    $display("up/down test done");
  endtask : t_updown

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset;
    t_t0;
    t_t1;
    t_t2;
    t_updown;
    finish_test;
  end
endmodule : three_timer_counter_unit_bench
